//--- dv/llps_glass.sv
`timescale 1ns/1ps
// ==========
// slow clock source on the glass side
module llps_glass #(
   parameter int HALF = 4
) (
   input wire logic clk_i,
   input wire logic en_i,
   output logic tick_o
);
   int n = 0;
   initial tick_o = 1'b0;
   always @(posedge clk_i)
   begin
      if (!en_i)
      begin
         n <= 0;
         tick_o <= 1'b0;
      end
      else if (n == HALF - 1)
      begin
         n <= 0;
         tick_o <= ~tick_o;
      end
      else
         n <= n + 1;
   end
endmodule : llps_glass

//--- dv/llps_sva.sv
`timescale 1ns/1ps
// ==========
// shadows and ladder checks
module llps_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [1:0] ladder_power_o,
   input wire logic ladder_short_mid_o,
   input wire logic phase_b_o,
   input wire logic contrast_on_o,
   input wire logic ref_on_o,
   input wire logic ref_buffer_on_o,
   input wire logic [3:1] bias_pin_connect_o,
   input wire logic [3:0] backplane_active_o
);
   logic [7:0] lad_r, ctl_r, ref_r;
   logic [1:0] qt_r;
   logic wr, qt, act;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign qt = (qt_r == 2'h3);
   assign act = qt & ctl_r[0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // outputs lag writes; judge settled states only
   always_ff @(posedge clk_i)
   begin
      qt_r <= (rst_i | wr) ? 2'h0 : (qt ? qt_r : qt_r + 2'h1);
      lad_r <= rst_i ? 8'h00 : ((wr & wb_adr_i == 8'h00) ? wb_dat_i[7:0] : lad_r);
      ctl_r <= rst_i ? 8'h00 : ((wr & wb_adr_i == 8'h04) ? wb_dat_i[7:0] : ctl_r);
      ref_r <= rst_i ? 8'h00 : ((wr & wb_adr_i == 8'h08) ? wb_dat_i[7:0] : ref_r);
   end
   a_off_ladder: assert property (qt && !ctl_r[0] |-> ladder_power_o == 2'h0)
      else $error("ladder on while inactive");
   a_off_contrast: assert property (qt && !ctl_r[0] |-> !contrast_on_o)
      else $error("contrast closed while inactive");
   a_off_ref: assert property (qt && !ctl_r[0] |-> !ref_on_o)
      else $error("reference on while inactive");
   a_half_short: assert property (act && ctl_r[1] |-> ladder_short_mid_o)
      else $error("middle resistor not shorted");
   a_power_a: assert property (act && $stable(phase_b_o) && !phase_b_o |->
      ladder_power_o == lad_r[7:6])
      else $error("wrong power in state A");
   a_power_b: assert property (act && $stable(phase_b_o) && phase_b_o |->
      ladder_power_o == lad_r[5:4])
      else $error("wrong power in state B");
   a_zero_len: assert property (act && !wb_cyc_i && lad_r[2:0] == 3'h0 |-> phase_b_o [*3])
      else $error("state A with zero length");
   a_buf_gate: assert property (act && ref_r[7:5] == 3'h7 && $stable(phase_b_o) |->
      ref_buffer_on_o == !phase_b_o)
      else $error("buffer not tied to state");
   a_pin_link: assert property (qt |-> bias_pin_connect_o == ref_r[3:1])
      else $error("bias pin link mismatch");
   a_com_mask: assert property (act |->
      backplane_active_o == 4'((5'h2 << ctl_r[5:4]) - 5'h1))
      else $error("active commons mismatch");
   c_phase_a: cover property (act && $fell(phase_b_o));
   c_buf_gate: cover property (act && ref_r[7:5] == 3'h7 && phase_b_o);
   c_all_coms: cover property (act && ctl_r[5:4] == 2'h3);
endmodule : llps_sva
bind llps_sequencer llps_sva u_sva (.*);

//--- dv/tb_llps_sequencer.sv
`timescale 1ns/1ps
module tb_llps_sequencer;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, tick_32k_i, ladder_short_mid_o, phase_b_o, contrast_on_o, ref_on_o;
   logic ref_buffer_on_o, fixed_source_on_o, gen = 1'b0;
   logic [1:0] ladder_power_o;
   logic [2:0] contrast_tap_o;
   logic [3:1] bias_pin_connect_o;
   logic [3:0] backplane_active_o, com_pin_dir_o;
   int n_errors = 0, samples_checked = 0, cyc_n = 0;
   initial forever #5 clk_i = ~clk_i;
   llps_glass gl (.clk_i(clk_i), .en_i(gen), .tick_o(tick_32k_i));
   llps_sequencer dut (.*);
   task automatic test_done;
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   // hang guard
   always @(posedge clk_i)
   begin
      cyc_n++;
      if (cyc_n == 20000)
      begin
         n_errors++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %0t got %0h want %0h", $time, g, e);
      end
   endtask : chk
   // ==========
   // classic wishbone, holds until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i iff wb_ack_o === 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic t_regs;
      chk(phase_b_o, 1);
      wb(0, 8'h14, 0);
      chk(q, 32'hF);
      wb(1, 8'h00, 32'hFF);
      wb(0, 8'h00, 0);
      chk(q, 32'hF7);
      wb(1, 8'h1C, 32'hFF);
      wb(0, 8'h1C, 0);
      chk(q, 0);
   endtask : t_regs
   task automatic t_off;
      wb(1, 8'h08, 32'hEE);
      wb(1, 8'h0C, 32'h7);
      repeat (4) @(posedge clk_i);
      chk(ladder_power_o, 0);
      chk(contrast_on_o, 0);
      chk(ref_on_o, 0);
   endtask : t_off
   task automatic t_on;
      wb(1, 8'h04, 32'h3);
      repeat (4) @(posedge clk_i);
      chk(ladder_short_mid_o, 1);
      chk(fixed_source_on_o, 1);
      chk(contrast_tap_o, 7);
      chk(bias_pin_connect_o, 7);
      wb(1, 8'h08, 32'h84);
      repeat (4) @(posedge clk_i);
      chk(fixed_source_on_o, 0);
      chk(bias_pin_connect_o, 2);
      wb(1, 8'h08, 32'h04);
      repeat (4) @(posedge clk_i);
      chk(contrast_on_o, 0);
   endtask : t_on
   task automatic t_mux;
      for (int m = 0; m < 4; m++)
      begin
         wb(1, 8'h04, 32'h1 | (m << 4));
         repeat (4) @(posedge clk_i);
         chk(backplane_active_o, (2 << m) - 1);
         chk(com_pin_dir_o, 4'hF & ~((2 << m) - 1));
      end
   endtask : t_mux
   task automatic t_zero;
      int k;
      k = 0;
      gen <= 1'b1;
      wb(1, 8'h00, 32'hD0);
      repeat (300) @(posedge clk_i) k += (phase_b_o !== 1'b1);
      chk(k, 0);
   endtask : t_zero
   task automatic t_seq(input int n, input int w);
      int k;
      wb(1, 8'h08, 32'hE0);
      wb(1, 8'h04, 32'h1 | (w << 2));
      wb(1, 8'h00, 32'hD0 | n);
      @(posedge clk_i iff phase_b_o === 1'b1);
      @(posedge clk_i iff phase_b_o === 1'b0);
      k = 0;
      while (phase_b_o === 1'b0)
      begin
         @(posedge clk_i);
         k++;
      end
      chk(k, n * 8);
      k = 0;
      while (phase_b_o === 1'b1)
      begin
         @(posedge clk_i);
         k++;
      end
      chk(k, ((16 << w) - n) * 8);
   endtask : t_seq
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_off();
      t_on();
      t_mux();
      t_zero();
      for (int w = 0; w < 2; w++)
      begin
         t_seq(1, w);
         t_seq(7, w);
      end
      test_done();
   end
endmodule : tb_llps_sequencer

//--- rtl/llps_sequencer.sv
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "llps_defines.svh"

// Summary of operation
// R1 - inactive module switches reference ladder off
// R2 - inactive module opens contrast ladder
// R3 - inactive module turns bias reference off
// R4 - half bias shorts middle ladder resistor
// R5 - interval A uses bits 7-6 power
// R6 - interval B uses bits 5-4 power
// R7 - bits 2-0 set A length; 0 always B
// R8 - type A period is 16 clocks
// R9 - type B period is 32 clocks
// R10 - A starts at segment transition
// R11 - prescaler count picks A or B
// R12 - idle gate with fixed source selected ties buffer to A state
// R13 - no reference selected disables contrast
// R14 - fixed reference enabled automatically when needed
// R15 - contrast tap picks one of eight
// R16 - common count selects active commons
// R17 - common pins ignore direction bits
// R18 - each bias pin independently controlled
// R19 - connect bit one links pin to bias
// R20 - restart count each transition, A below length
module llps_sequencer #(
   parameter int PRE_W = 5
) (
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // 32 kHz tick pin
   input wire logic tick_32k_i,
   // ladder analog controls
   output logic [1:0] ladder_power_o,
   output logic ladder_short_mid_o,
   output logic phase_b_o,
   output logic contrast_on_o,
   output logic [2:0] contrast_tap_o,
   output logic ref_on_o,
   output logic ref_buffer_on_o,
   output logic fixed_source_on_o,
   output logic [3:1] bias_pin_connect_o,
   // common pins
   output logic [3:0] backplane_active_o,
   output logic [3:0] com_pin_dir_o
);

   // the phase compare assumes a 32-count prescaler
   if (PRE_W != 5)
   begin : g_bad_pre_w
      $error("prescaler must be 5 bits");
   end

   // ==========================================================
   // registers
   // ==========================================================
   logic [7:0] ladder_power_control_r;
   logic [7:0] control_r;
   logic [7:0] bias_source_control_r;
   logic [2:0] contrast_tap_select_r;
   logic [3:0] pin_direction_bits_r;
   logic [PRE_W-1:0] pre_cnt_r;
   logic phase_b_r;
   logic tick_meta_r;
   logic tick_sync_r;
   logic tick_old_r;

   function automatic logic lane_ok(input logic [7:0] adr, input logic [7:0] off);
      lane_ok = (adr == off);
   endfunction : lane_ok

   // ==========================================================
   // bus handshake
   // ==========================================================
   // ack drops for a cycle after each transfer, so a held strobe is taken again every second cycle
   logic wr;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ladder_power_control_r <= `LLPS_LADDER_RST;
      else if (wr && lane_ok(wb_adr_i, 8'(`LLPS_OFF_LADDER)))
         ladder_power_control_r <= wb_dat_i[7:0] & `LLPS_LADDER_MASK;
   end

   // unused control bits are stored as zero so reads show them clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         control_r <= `LLPS_CTL_RST;
      else if (wr && lane_ok(wb_adr_i, 8'(`LLPS_OFF_CONTROL)))
         control_r <= {2'h0, wb_dat_i[5:4], 1'b0, wb_dat_i[2:0]};
   end

   // R18 independent pin bits
   // each pin bit is a plain flop, so any subset may be connected
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bias_source_control_r <= `LLPS_REF_RST;
      else if (wr && lane_ok(wb_adr_i, 8'(`LLPS_OFF_REFCTL)))
         bias_source_control_r <= wb_dat_i[7:0] & `LLPS_REF_MASK;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         contrast_tap_select_r <= `LLPS_CST_RST;
      else if (wr && lane_ok(wb_adr_i, 8'(`LLPS_OFF_CONTRAST)))
         contrast_tap_select_r <= wb_dat_i[2:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pin_direction_bits_r <= `LLPS_PINDIR_RST;
      else if (wr && lane_ok(wb_adr_i, 8'(`LLPS_OFF_PINDIR)))
         pin_direction_bits_r <= wb_dat_i[3:0];
   end

   logic active;
   logic half_bias;
   logic waveform_type_select;
   logic [1:0] mux_sel;
   logic [2:0] a_len;
   assign active = control_r[`LLPS_CTL_ACTIVE];
   assign half_bias = control_r[`LLPS_CTL_HALF];
   assign waveform_type_select = control_r[`LLPS_CTL_WFT];
   assign mux_sel = control_r[`LLPS_CTL_MUX_MSB:`LLPS_CTL_MUX_LSB];
   assign a_len = ladder_power_control_r[`LLPS_AT_MSB:`LLPS_AT_LSB];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h0000_0000;
      else
      begin
         case (wb_adr_i)
            8'(`LLPS_OFF_LADDER): wb_dat_o <= {24'h0, ladder_power_control_r};
            8'(`LLPS_OFF_CONTROL): wb_dat_o <= {24'h0, control_r};
            8'(`LLPS_OFF_REFCTL): wb_dat_o <= {24'h0, bias_source_control_r};
            8'(`LLPS_OFF_CONTRAST): wb_dat_o <= {29'h0, contrast_tap_select_r};
            8'(`LLPS_OFF_STATUS): wb_dat_o <= {22'h0, ladder_power_o, 2'h0,
                                                 pre_cnt_r, phase_b_r};
            8'(`LLPS_OFF_PINDIR): wb_dat_o <= {28'h0, pin_direction_bits_r};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // 32 kHz tick and prescaler
   // ==========================================================
   // tick is asynchronous; only the second stage feeds the edge detect
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tick_meta_r <= 1'b0;
         tick_sync_r <= 1'b0;
         tick_old_r <= 1'b0;
      end
      else
      begin
         tick_meta_r <= tick_32k_i;
         tick_sync_r <= tick_meta_r;
         tick_old_r <= tick_sync_r;
      end
   end

   logic tick;
   assign tick = tick_sync_r && !tick_old_r;

   // R11 prescaler drives phase
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !active)
         pre_cnt_r <= '0;
      else if (tick)
         pre_cnt_r <= pre_cnt_r + 5'h01;
   end

   // R8 type A: 16-clock period (upper bit ignored), R9 type B: 32
   // the type A count wraps twice per prescaler turn
   logic [4:0] in_period;
   assign in_period = waveform_type_select ? pre_cnt_r : {1'b0, pre_cnt_r[3:0]};

   // R10 A begins at the transition when the count wraps
   // R20 count restarts each period, A while below length
   // R7 zero length keeps state B
   logic phase_b_nxt;
   assign phase_b_nxt = !(in_period < {2'b00, a_len});

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         phase_b_r <= 1'b1;
      else
         phase_b_r <= phase_b_nxt;
   end

   // ==========================================================
   // ladder outputs
   // ==========================================================
   // both power fields share one encoding
   function automatic llps_pkg::llps_pwr_t pwr_of(input logic [1:0] field);
      pwr_of = llps_pkg::llps_pwr_t'(field);
   endfunction : pwr_of

   llps_pkg::llps_pwr_t pwr_nxt;
   always_comb
   begin
      // R5 interval A field, R6 interval B field
      if (phase_b_nxt)
         pwr_nxt = pwr_of(ladder_power_control_r[`LLPS_BP_MSB:`LLPS_BP_LSB]);
      else
         pwr_nxt = pwr_of(ladder_power_control_r[`LLPS_AP_MSB:`LLPS_AP_LSB]);
      // R1 inactive forces ladder off
      if (!active)
         pwr_nxt = llps_pkg::LLPS_PWR_OFF;
   end

   logic ref_sel;
   logic ref_fixed;
   logic ref_idle;
   assign ref_sel = bias_source_control_r[`LLPS_REF_EN];
   assign ref_fixed = bias_source_control_r[`LLPS_REF_FIXED];
   assign ref_idle = bias_source_control_r[`LLPS_REF_IDLE];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ladder_power_o <= 2'h0;
      else
         ladder_power_o <= pwr_nxt;
   end

   // R4 half bias short
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ladder_short_mid_o <= 1'b0;
      else
         ladder_short_mid_o <= half_bias;
   end

   // phase flag leaves with the power level it chose
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         phase_b_o <= 1'b1;
      else
         phase_b_o <= phase_b_nxt;
   end

   // ==========================================================
   // reference and contrast
   // ==========================================================
   // R2 contrast open when inactive, R13 no reference disables it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         contrast_on_o <= 1'b0;
      else
         contrast_on_o <= active && ref_sel;
   end

   // R15 tap select
   // tap keeps its value while inactive; the open ladder makes it moot
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         contrast_tap_o <= 3'h0;
      else
         contrast_tap_o <= contrast_tap_select_r;
   end

   // R3 reference off when inactive
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ref_on_o <= 1'b0;
      else
         ref_on_o <= active && ref_sel;
   end

   // R12 buffer follows A state when idle gate and fixed source bits are both set
   // gating only saves power when the fixed source feeds the reference
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ref_buffer_on_o <= 1'b0;
      else
         ref_buffer_on_o <= active && ref_sel && (!ref_fixed || !ref_idle || !phase_b_nxt);
   end

   // R14 fixed source on automatically
   // software never starts the fixed source itself
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fixed_source_on_o <= 1'b0;
      else
         fixed_source_on_o <= active && ref_sel && ref_fixed;
   end

   // ==========================================================
   // bias pins
   // ==========================================================
   // R19 connect bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bias_pin_connect_o <= 3'h0;
      else
         bias_pin_connect_o <= bias_source_control_r[`LLPS_REF_PIN3:`LLPS_REF_PIN1];
   end

   // ==========================================================
   // commons
   // ==========================================================
   function automatic logic [3:0] com_mask(input logic [1:0] sel);
      case (sel)
         2'h0: com_mask = 4'h1;
         2'h1: com_mask = 4'h3;
         2'h2: com_mask = 4'h7;
         default: com_mask = 4'hF;
      endcase
   endfunction : com_mask

   // R16 common count decode
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         backplane_active_o <= 4'h0;
      else
         backplane_active_o <= active ? com_mask(mux_sel) : 4'h0;
   end

   // R17 common drive overrides direction (0 = output)
   // pins outside the common set keep the software direction
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         com_pin_dir_o <= `LLPS_PINDIR_RST;
      else
         com_pin_dir_o <= pin_direction_bits_r & ~(active ? com_mask(mux_sel) : 4'h0);
   end

   logic unused;
   assign unused = ^{wb_sel_i[3:1], wb_dat_i[31:8]};

endmodule : llps_sequencer

//--- shared/llps_defines.svh
`ifndef LLPS_DEFINES_SVH
`define LLPS_DEFINES_SVH

// register word offsets (byte addresses)
`define LLPS_OFF_LADDER 4'h0
`define LLPS_OFF_CONTROL 4'h4
`define LLPS_OFF_REFCTL 4'h8
`define LLPS_OFF_CONTRAST 4'hC
`define LLPS_OFF_STATUS 5'h10
`define LLPS_OFF_PINDIR 5'h14

// ladder_power_control fields
`define LLPS_AP_MSB 7
`define LLPS_AP_LSB 6
`define LLPS_BP_MSB 5
`define LLPS_BP_LSB 4
`define LLPS_AT_MSB 2
`define LLPS_AT_LSB 0
`define LLPS_LADDER_RST 8'h00
`define LLPS_LADDER_MASK 8'hF7

// control register fields
`define LLPS_CTL_ACTIVE 0
`define LLPS_CTL_HALF 1
`define LLPS_CTL_WFT 2
`define LLPS_CTL_MUX_LSB 4
`define LLPS_CTL_MUX_MSB 5
`define LLPS_CTL_RST 8'h00

// bias source control fields
`define LLPS_REF_EN 7
`define LLPS_REF_FIXED 6
`define LLPS_REF_IDLE 5
`define LLPS_REF_PIN3 3
`define LLPS_REF_PIN1 1
`define LLPS_REF_RST 8'h00
`define LLPS_REF_MASK 8'hEE

`define LLPS_CST_RST 3'h0
`define LLPS_PINDIR_RST 4'hF

// 5-bit prescaler: 32 clocks per base period
`define LLPS_PRE_TOP 5'h1F
`define LLPS_HALF_TOP 5'h0F

`endif

//--- shared/llps_pkg.sv
package llps_pkg;
   typedef enum logic [1:0] {
      LLPS_PWR_OFF = 2'b00,
      LLPS_PWR_LOW = 2'b01,
      LLPS_PWR_MED = 2'b10,
      LLPS_PWR_HIGH = 2'b11
   } llps_pwr_t;
   typedef enum logic [0:0] {
      LLPS_ST_A = 1'b0,
      LLPS_ST_B = 1'b1
   } llps_phase_t;
endpackage : llps_pkg
